/* File: rtl/tfc_codec.sv */
// tape frame codec: bcd conversion, parity, frame strobes, write termination
//
// Added by the designer: the Wishbone register port and the register addresses.
`default_nettype none

module tfc_codec (
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	input  wire logic                      ce_i,
	// wishbone classic slave
	input  wire logic                      wb_cyc_i,
	input  wire logic                      wb_stb_i,
	input  wire logic                      wb_we_i,
	input  wire logic [7:0]                wb_adr_i,
	input  wire logic [3:0]                wb_sel_i,
	input  wire logic [31:0]               wb_dat_i,
	output logic      [31:0]               wb_dat_o,
	output logic                           wb_ack_o,
	// channel side
	input  wire logic                      negate_bcd_i,
	output logic [tfc_pkg::NUM_STAT-1:0]   status_o,
	output logic                           irq_o,
	// tape handler side
	input  wire logic [6:0]                rd_frame_i,
	input  wire logic                      rd_strobe_i,
	input  wire logic                      write_permit_i,
	input  wire logic                      end_of_record_i,
	output tfc_pkg::tfc_tape_out_type      tape_o
);

	tfc_pkg::tfc_state_type q;
	tfc_pkg::tfc_state_type d;
	tfc_pkg::tfc_pins_type  pins;
	logic [10:0]            pins_raw;
	logic [10:0]            pins_syn;
	logic [tfc_pkg::NUM_STAT-1:0] lines;

	// byte lane mask from the select lines
	function automatic logic [31:0] lane_mask(input logic [3:0] sel);
		lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction

	// bcd conversion, shared by write and read paths
	function automatic logic [5:0] bcd_conv(input logic [5:0] c, input logic en);
		logic [5:0] r;
		r = c;
		if (en && c[tfc_pkg::BIT_FIVE]) begin
			r[tfc_pkg::BIT_SIX] = ~c[tfc_pkg::BIT_SIX];
		end
		bcd_conv = r;
	endfunction

	// transverse parity bit for six data bits
	function automatic logic frame_par(input logic [5:0] c, input logic odd);
		frame_par = (^c) ^ odd;
	endfunction

	// all handler and channel lines come from another domain
	assign pins_raw = {rd_frame_i, rd_strobe_i, write_permit_i, end_of_record_i, negate_bcd_i};

	tfc_sync3 #(
		.W (11)
	) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.ce_i  (ce_i),
		.d_i   (pins_raw),
		.q_o   (pins_syn)
	);

	assign pins = tfc_pkg::tfc_pins_type'(pins_syn);

	always_comb begin
		lines     = '0;
		lines[0]  = (q.st != tfc_pkg::TFC_IDLE);
		lines[1]  = pins.permit;
		lines[2]  = q.rd_valid;
		lines[3]  = q.hold_full;
		lines[4]  = q.ists[tfc_pkg::IRQ_CHPAR];
		lines[5]  = q.ists[tfc_pkg::IRQ_REPLY];
		lines[6]  = q.ists[tfc_pkg::IRQ_RDPAR];
		lines[7]  = q.ists[tfc_pkg::IRQ_OVR];
		lines[8]  = q.ists[tfc_pkg::IRQ_ABORT];
		lines[9]  = q.ists[tfc_pkg::IRQ_DONE];
		lines[10] = q.bcd;
		lines[11] = pins.negate;
	end

	// next state of the whole codec
	always_comb begin
		logic                       acc;
		logic                       conv_en;
		logic [31:0]                lm;
		logic [31:0]                wv;
		logic [tfc_pkg::NUM_IRQ-1:0] ev;
		logic [tfc_pkg::NUM_IRQ-1:0] clr;
		logic [5:0]                 c;
		logic                       rs_rise;
		logic                       eor_rise;
		logic                       go;
		logic                       rd_take;
		acc      = wb_cyc_i && wb_stb_i && !q.ack;
		conv_en  = q.bcd && !pins.negate;
		lm       = lane_mask(wb_sel_i);
		wv       = wb_dat_i & lm;
		ev       = '0;
		clr      = '0;
		c        = '0;
		rs_rise  = pins.rd_strobe && !q.rs_prev;
		eor_rise = pins.eor && !q.eor_prev;
		go       = 1'b0;
		rd_take  = 1'b0;
		d        = q;
		d.ack    = 1'b0;
		d.tape.strobe = 1'b0;
		d.rs_prev  = pins.rd_strobe;
		d.eor_prev = pins.eor;

		// write sequencer; frames leave at the programmed pace
		case (q.st)
			tfc_pkg::TFC_IDLE: begin
				d.cnt = '0;
			end
			tfc_pkg::TFC_DATA: begin
				if (q.cnt != '0) begin
					d.cnt = q.cnt - 16'h0001;
				end else if (q.hold_full) begin
					c = bcd_conv(q.hold, conv_en);
					// parity in the top bit above the six data bits, data bits on fixed tracks
					d.tape.frame  = {frame_par(c, q.podd), c};
					d.tape.strobe = 1'b1;
					d.lrc         = q.lrc ^ c;
					d.hold_full   = 1'b0;
					d.cnt         = q.period;
				end else if (q.end_req) begin
					d.st  = tfc_pkg::TFC_GAP;
					d.gap = tfc_pkg::GAP_FRAMES - 2'h1;
					d.cnt = q.period;
				end
			end
			tfc_pkg::TFC_GAP: begin
				if (q.cnt != '0) begin
					d.cnt = q.cnt - 16'h0001;
				end else if (q.gap == 2'h0) begin
					d.st = tfc_pkg::TFC_CHECK;
				end else begin
					d.gap = q.gap - 2'h1;
					d.cnt = q.period;
				end
			end
			tfc_pkg::TFC_CHECK: begin
				d.tape.frame  = {frame_par(q.lrc, q.podd), q.lrc};
				d.tape.strobe = 1'b1;
				d.st          = tfc_pkg::TFC_WAIT;
			end
			tfc_pkg::TFC_WAIT: begin
				// end of record from the handler's end of record line
				if (eor_rise) begin
					d.st          = tfc_pkg::TFC_IDLE;
					ev[tfc_pkg::IRQ_DONE] = 1'b1;
				end
			end
			default: begin
				d.st = tfc_pkg::TFC_IDLE;
			end
		endcase

		// losing the ring aborts any write in progress
		if (q.st != tfc_pkg::TFC_IDLE && !pins.permit) begin
			d.st          = tfc_pkg::TFC_IDLE;
			d.tape.strobe = 1'b0;
			d.tape.frame  = q.tape.frame; // a killed frame never reaches the tracks
			ev[tfc_pkg::IRQ_ABORT] = 1'b1;
		end

		// register access, if and else-if decode
		if (acc) begin
			d.ack  = 1'b1;
			d.rdat = '0;
			if (wb_adr_i == tfc_pkg::ADR_CTRL) begin
				d.rdat[tfc_pkg::CTRL_BCD]  = q.bcd;
				d.rdat[tfc_pkg::CTRL_PODD] = q.podd;
				d.rdat[tfc_pkg::CTRL_CODD] = q.codd;
				if (wb_we_i && wb_sel_i[0]) begin
					d.bcd  = wv[tfc_pkg::CTRL_BCD];
					d.podd = wv[tfc_pkg::CTRL_PODD];
					d.codd = wv[tfc_pkg::CTRL_CODD];
					go     = wv[tfc_pkg::CTRL_GO];
				end
			end else if (wb_adr_i == tfc_pkg::ADR_STATUS) begin
				d.rdat[tfc_pkg::NUM_STAT-1:0] = lines;
				d.rdat[18:16] = q.st;
			end else if (wb_adr_i == tfc_pkg::ADR_IRQ_STS) begin
				d.rdat[tfc_pkg::NUM_IRQ-1:0] = q.ists;
				if (wb_we_i) begin
					clr = wv[tfc_pkg::NUM_IRQ-1:0];
				end
			end else if (wb_adr_i == tfc_pkg::ADR_IRQ_MSK) begin
				d.rdat[tfc_pkg::NUM_IRQ-1:0] = q.imsk;
				if (wb_we_i && wb_sel_i[0]) begin
					d.imsk = wv[tfc_pkg::NUM_IRQ-1:0];
				end
			end else if (wb_adr_i == tfc_pkg::ADR_WDATA) begin
				d.rdat[5:0] = q.hold;
				if (wb_we_i && wb_sel_i[0]) begin
					if ((^wv[tfc_pkg::WDATA_PAR:0]) != q.codd) begin
						ev[tfc_pkg::IRQ_CHPAR] = 1'b1;
					end
					// a holding stage still full after this cycle's frame drops the word
					if (d.hold_full) begin
						ev[tfc_pkg::IRQ_OVR] = 1'b1;
					end else begin
						d.hold      = wv[5:0];
						d.hold_full = 1'b1;
					end
				end
			end else if (wb_adr_i == tfc_pkg::ADR_RDATA) begin
				d.rdat[5:0]               = q.rd_data;
				d.rdat[tfc_pkg::RDATA_VLD] = q.rd_valid;
				if (!wb_we_i) begin
					d.rd_valid = 1'b0;
				end
			end else if (wb_adr_i == tfc_pkg::ADR_PERIOD) begin
				d.rdat[15:0] = q.period;
				if (wb_we_i) begin
					// lanes 0 and 1 only; upper lanes have no bits here
					d.period = (q.period & ~lm[15:0]) | wv[15:0];
				end
			end else if (wb_adr_i == tfc_pkg::ADR_END) begin
				d.rdat[0] = q.end_req;
				if (wb_we_i && wb_sel_i[0] && wv[0] && q.st == tfc_pkg::TFC_DATA) begin
					d.end_req = 1'b1;
				end
			end else if (wb_adr_i == tfc_pkg::ADR_STATREQ) begin
				d.rdat[4:0] = q.resp;
				// request code picks a condition, answer encodes it
				if (wb_we_i && wb_sel_i[0]) begin
					if (wv[3:0] < 4'(tfc_pkg::NUM_STAT)) begin
						d.resp = {lines[wv[3:0]], wv[3:0]};
					end else begin
						d.resp = {1'b0, wv[3:0]};
					end
				end
			end else begin
				// unmapped: acknowledged, reads zero
				d.rdat = '0;
			end
		end

		if (go && q.st == tfc_pkg::TFC_IDLE) begin
			if (pins.permit) begin
				d.st      = tfc_pkg::TFC_DATA;
				d.lrc     = '0;
				d.end_req = 1'b0;
				d.cnt     = '0;
			end else begin
				ev[tfc_pkg::IRQ_ABORT] = 1'b1;
			end
		end

		// incoming frames: reply while writing, data otherwise
		if (rs_rise) begin
			if (q.st != tfc_pkg::TFC_IDLE) begin
				if ((^pins.rd_frame) != q.podd) begin
					ev[tfc_pkg::IRQ_REPLY] = 1'b1;
				end
			end else begin
				rd_take = 1'b1;
				if ((^pins.rd_frame) != q.podd) begin
					ev[tfc_pkg::IRQ_RDPAR] = 1'b1;
				end
			end
		end

		// convert on the way in; new frame beats a read clear
		if (rd_take) begin
			if (q.rd_valid && d.rd_valid) begin
				ev[tfc_pkg::IRQ_OVR] = 1'b1;
			end
			d.rd_data  = bcd_conv(pins.rd_frame[5:0], conv_en);
			d.rd_valid = 1'b1;
			ev[tfc_pkg::IRQ_RDRDY] = 1'b1;
		end

		// sticky flags, a new event wins over the clear
		d.ists = (q.ists & ~clr) | ev;
	end

	// single register stage for the whole state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q          <= '0;
			q.period   <= tfc_pkg::FRAME_CYCLES;
			q.imsk     <= tfc_pkg::RST_IRQ_MSK;
			q.st       <= tfc_pkg::TFC_IDLE;
		end else if (ce_i) begin
			q <= d;
		end
	end

	// outputs straight from the state
	assign wb_ack_o = q.ack;
	assign wb_dat_o = q.rdat;
	assign tape_o   = q.tape;
	assign status_o = lines;
	assign irq_o    = |(q.ists & q.imsk);

endmodule

`default_nettype wire

/* File: rtl/tfc_pkg.sv */
// constants, types and state layout shared by the tape frame codec
// Function
// - on a write in bcd mode a character with bit five set gets bit six inverted.
// - on a read in bcd mode a frame with bit five set gets bit six inverted.
// - while the channel asserts the bcd inhibit line characters pass unchanged both ways.
// - every recorded frame is six data bits plus one transverse parity bit of chosen sense.
// - the parity bit sent with every channel output word is checked.
// - one write frame strobe goes to the handler per written frame, paced for density.
// - the handler returns each written frame and its parity is checked on return.
// - when output stops the gap is left, the check character written, then end of record awaited.
// - writing proceeds only while the handler's write permit line is present.
// - twelve status lines are presented, each high while its condition exists. Lines 4 to 9 are sticky flags that stay high until cleared.
// - a status request code is answered with a status response code of the conditions.
// - each bit position of a frame always goes to the same fixed track.
// - a record is closed by three blank frame times then the check character.
`default_nettype none

package tfc_pkg;

	// clock and frame pacing
	localparam int          CLK_PERIOD_NS   = 25;
	localparam int          FRAME_PERIOD_NS = 10000;
	localparam logic [15:0] FRAME_CYCLES    = 16'(FRAME_PERIOD_NS / CLK_PERIOD_NS);
	localparam logic [1:0]  GAP_FRAMES      = 2'h3;

	// register byte offsets
	localparam logic [7:0] ADR_CTRL    = 8'h00;
	localparam logic [7:0] ADR_STATUS  = 8'h04;
	localparam logic [7:0] ADR_IRQ_STS = 8'h08;
	localparam logic [7:0] ADR_IRQ_MSK = 8'h0c;
	localparam logic [7:0] ADR_WDATA   = 8'h10;
	localparam logic [7:0] ADR_RDATA   = 8'h14;
	localparam logic [7:0] ADR_PERIOD  = 8'h18;
	localparam logic [7:0] ADR_END     = 8'h1c;
	localparam logic [7:0] ADR_STATREQ = 8'h20;

	// control and data register field positions
	localparam int CTRL_BCD   = 0;
	localparam int CTRL_PODD  = 1;
	localparam int CTRL_CODD  = 2;
	localparam int CTRL_GO    = 3;
	localparam int WDATA_PAR  = 6;
	localparam int RDATA_VLD  = 8;

	// bit five and bit six of a character
	localparam int BIT_FIVE = 4;
	localparam int BIT_SIX  = 5;

	// interrupt status bit positions
	localparam int IRQ_CHPAR = 0;
	localparam int IRQ_REPLY = 1;
	localparam int IRQ_RDPAR = 2;
	localparam int IRQ_OVR   = 3;
	localparam int IRQ_ABORT = 4;
	localparam int IRQ_DONE  = 5;
	localparam int IRQ_RDRDY = 6;
	localparam int NUM_IRQ   = 7;
	localparam int NUM_STAT  = 12;

	// reset values
	localparam logic [6:0] RST_IRQ_MSK = 7'h00;

	// write sequencer, gray from idle through wait; the return from wait to idle flips two bits
	typedef enum logic [2:0] {
		TFC_IDLE  = 3'b000,
		TFC_DATA  = 3'b001,
		TFC_GAP   = 3'b011,
		TFC_CHECK = 3'b010,
		TFC_WAIT  = 3'b110
	} tfc_wstate_type;

	// frame and strobe toward the handler
	typedef struct packed {
		logic [6:0] frame;
		logic       strobe;
	} tfc_tape_out_type;

	// synchronised handler and channel lines
	typedef struct packed {
		logic [6:0] rd_frame;
		logic       rd_strobe;
		logic       permit;
		logic       eor;
		logic       negate;
	} tfc_pins_type;

	// whole state of the codec
	typedef struct packed {
		logic                  ack;
		logic [31:0]           rdat;
		logic                  bcd;
		logic                  podd;
		logic                  codd;
		logic [15:0]           period;
		logic [NUM_IRQ-1:0]    ists;
		logic [NUM_IRQ-1:0]    imsk;
		logic [5:0]            hold;
		logic                  hold_full;
		logic [5:0]            rd_data;
		logic                  rd_valid;
		tfc_wstate_type        st;
		logic [15:0]           cnt;
		logic [1:0]            gap;
		logic [5:0]            lrc;
		logic                  end_req;
		tfc_tape_out_type      tape;
		logic                  rs_prev;
		logic                  eor_prev;
		logic [4:0]            resp;
	} tfc_state_type;

endpackage

`default_nettype wire

/* File: rtl/tfc_sync3.sv */
// three-stage synchroniser for pins entering the codec clock domain
`default_nettype none

module tfc_sync3 #(
	parameter int W = 11
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         ce_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} tfc_sync_st_type;

	tfc_sync_st_type st_q;
	tfc_sync_st_type st_d;
	logic [W-1:0]    agree;

	// a change is taken only once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : gen_bit
			assign agree[g] = st_q.s2[g] ~^ st_q.s3[g];
		end
	endgenerate

	// shift chain; stage one feeds stage two only
	always_comb begin
		st_d    = st_q;
		st_d.s1 = d_i;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		st_d.q  = (st_q.q & ~agree) | (st_q.s3 & agree);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= '0;
		end else if (ce_i) begin
			st_q <= st_d;
		end
	end

	assign q_o = st_q.q;

endmodule

`default_nettype wire

/* File: dv/tfc_codec_properties.sv */
// port assertions for the tape frame codec
`default_nettype none

module tfc_codec_properties (
	input wire logic                         clk_i,
	input wire logic                         rst_i,
	input wire logic                         wb_cyc_i,
	input wire logic                         wb_stb_i,
	input wire logic                         wb_we_i,
	input wire logic                         wb_ack_o,
	input wire logic [tfc_pkg::NUM_STAT-1:0] status_o,
	input wire tfc_pkg::tfc_tape_out_type    tape_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// bus answer one cycle after a taken request, one cycle wide
	AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing");
	AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	AST_STB_PULSE: assert property (tape_o.strobe |=> !tape_o.strobe)
		else $error("strobe too long");
	AST_STB_BUSY: assert property (tape_o.strobe |-> $past(status_o[0]))
		else $error("strobe while idle");
	AST_STB_PERMIT: assert property (tape_o.strobe |-> $past(status_o[1]))
		else $error("strobe without permit");
	AST_ABORT: assert property (status_o[0] && !status_o[1] |=> !status_o[0])
		else $error("write kept without permit");
	// the track pattern may only move with a strobe
	AST_FRAME_HOLD: assert property (!tape_o.strobe |-> $stable(tape_o.frame))
		else $error("frame moved without strobe");
	AST_FLAG_STICKY: assert property (|($past(status_o[9:4]) & ~status_o[9:4]) |-> wb_ack_o && wb_we_i)
		else $error("flag fell without write");
	AST_BCD_WRITE: assert property ($changed(status_o[10]) |-> wb_ack_o && wb_we_i)
		else $error("bcd line moved alone");

	COV_STROBE: cover property (tape_o.strobe);
	COV_ABORT: cover property ($rose(status_o[8]));
	COV_DONE: cover property ($rose(status_o[9]));
endmodule

bind tfc_codec tfc_codec_properties u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .status_o(status_o),
	.tape_o(tape_o));

`default_nettype wire

/* File: dv/tfc_handler_model.sv */
// tape handler model: echoes written frames, senses read frames
`default_nettype none

module tfc_handler_model (
	input  wire logic                      clk_i,
	input  wire tfc_pkg::tfc_tape_out_type tape_i,
	output logic [6:0]                     frame_o,
	output logic                           strobe_o,
	output logic                           eor_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic bad;

	initial begin
		bad = 1'b0;
		frame_o = 7'h00;
		strobe_o = 1'b0;
		eor_o = 1'b0;
	end

	// frame settled before and through the strobe
	task automatic send(input logic [6:0] f);
		frame_o <= f;
		repeat (3) @(posedge clk_i);
		strobe_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		strobe_o <= 1'b0;
		repeat (3) @(posedge clk_i);
		// released lines show the inverse, never a stale frame
		frame_o <= ~f;
	endtask

	// every written frame strobed 11 or more cycles after the last one returns, corrupted only on request
	always @(posedge clk_i) begin
		if (tape_i.strobe === 1'b1) begin
			send(tape_i.frame ^ {bad, 6'h00});
		end
	end

	// end of record after the check character
	task automatic pulse_eor();
		eor_o <= 1'b1;
		repeat (6) @(posedge clk_i);
		eor_o <= 1'b0;
	endtask
endmodule

`default_nettype wire

/* File: dv/tb_tfc_codec.sv */
// testbench for the tape frame codec
`default_nettype none

module tb_tfc_codec;
	timeunit 1ns;
	timeprecision 1ps;
	logic                      clk_i = 1'b0;
	logic                      rst_i = 1'b1;
	logic                      cyc = 1'b0;
	logic                      stb = 1'b0;
	logic                      we = 1'b0;
	logic                      neg = 1'b0;
	logic                      perm = 1'b1;
	logic [7:0]                adr = 8'h00;
	logic [3:0]                sel = 4'h0;
	logic [31:0]               wdat = 32'h0;
	logic [31:0]               q;
	logic [31:0]               dout;
	logic                      ack;
	logic                      irq;
	logic [11:0]               st;
	logic [6:0]                rfr;
	logic                      rstb;
	logic                      eor;
	logic [5:0]                lrc;
	tfc_pkg::tfc_tape_out_type tape;
	int                        error_cnt = 0;
	int                        tests_run = 0;
	int                        cyc_n = 0;
	int                        n;

	always #12.5 clk_i = ~clk_i;

	tfc_codec dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dout),
		.wb_ack_o(ack), .negate_bcd_i(neg), .status_o(st), .irq_o(irq), .rd_frame_i(rfr),
		.rd_strobe_i(rstb), .write_permit_i(perm), .end_of_record_i(eor), .tape_o(tape));

	tfc_handler_model hm (.clk_i(clk_i), .tape_i(tape), .frame_o(rfr), .strobe_o(rstb),
		.eor_o(eor));

	task automatic wrap_up();
		if (error_cnt == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s exp %h got %h", nm, exp, got);
		end
	endtask

	// one classic cycle; data taken at the rising edge where ack is high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'h3;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = dout;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic waits();
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
		end while (tape.strobe !== 1'b1);
	endtask

	// write one character and compare the recorded frame
	task automatic emit(input logic [5:0] c, input logic cv);
		logic [5:0] v;
		v = c ^ {cv & c[4], 5'h00};
		xfer(1'b1, tfc_pkg::ADR_WDATA, {25'h0, ^c, c});
		waits();
		chk("frame", 32'(tape.frame), {25'h0, ^v, v});
		lrc ^= v;
	endtask

	// after the check character, let the reply settle, then end of record
	task automatic close_rec();
		repeat (12) @(posedge clk_i);
		hm.pulse_eor();
		do @(negedge clk_i); while (st[0] !== 1'b0);
	endtask

	// hang guard, far above the expected run
	always @(posedge clk_i) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 8000) begin
			error_cnt++;
			wrap_up();
		end
	end

	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		xfer(1'b0, tfc_pkg::ADR_PERIOD, 32'h0);
		chk("period", q, 32'h190);
		xfer(1'b0, tfc_pkg::ADR_IRQ_MSK, 32'h0);
		chk("mask", q, 32'h0);
		xfer(1'b1, 8'h24, 32'hff);
		xfer(1'b0, 8'h24, 32'h0);
		chk("unmapped", q, 32'h0);
		xfer(1'b1, tfc_pkg::ADR_PERIOD, 32'h14);
		xfer(1'b1, tfc_pkg::ADR_IRQ_MSK, 32'h7f);
		xfer(1'b1, tfc_pkg::ADR_CTRL, 32'h1);
		xfer(1'b0, tfc_pkg::ADR_CTRL, 32'h0);
		chk("ctrl", q, 32'h1);
		// bcd record, then gap, check character and end of record
		lrc = 6'h00;
		xfer(1'b1, tfc_pkg::ADR_CTRL, 32'h9);
		emit(6'h10, 1'b1);
		emit(6'h25, 1'b1);
		emit(6'h3f, 1'b1);
		xfer(1'b1, tfc_pkg::ADR_END, 32'h1);
		waits();
		chk("gap", 32'(n > 60), 32'h1);
		chk("check", 32'(tape.frame), {25'h0, ^lrc, lrc});
		close_rec();
		chk("done", 32'(st[9]), 32'h1);
		chk("irq", 32'(irq), 32'h1);
		chk("reply", 32'(st[5]), 32'h0);
		xfer(1'b1, tfc_pkg::ADR_IRQ_MSK, 32'h0);
		chk("irqmask", 32'(irq), 32'h0);
		// inhibit held, replies corrupted by the handler
		neg <= 1'b1;
		hm.bad = 1'b1;
		repeat (5) @(posedge clk_i);
		chk("negline", 32'(st[11]), 32'h1);
		xfer(1'b1, tfc_pkg::ADR_CTRL, 32'h9);
		emit(6'h10, 1'b0);
		xfer(1'b1, tfc_pkg::ADR_END, 32'h1);
		waits();
		close_rec();
		chk("replyerr", 32'(st[5]), 32'h1);
		hm.bad = 1'b0;
		neg <= 1'b0;
		xfer(1'b1, tfc_pkg::ADR_WDATA, 32'h01);
		chk("chanpar", 32'(st[4]), 32'h1);
		chk("holdfull", 32'(st[3]), 32'h1);
		xfer(1'b1, tfc_pkg::ADR_WDATA, 32'h41);
		chk("overrun", 32'(st[7]), 32'h1);
		xfer(1'b1, tfc_pkg::ADR_IRQ_STS, 32'h7f);
		chk("cleared", 32'(st[9:4]), 32'h0);
		// read path, bcd conversion and parity
		repeat (5) @(posedge clk_i);
		hm.send(7'h5a);
		repeat (4) @(posedge clk_i);
		chk("rdvalid", 32'(st[2]), 32'h1);
		xfer(1'b0, tfc_pkg::ADR_RDATA, 32'h0);
		chk("rdata", q, 32'h13a);
		hm.send(7'h45);
		repeat (4) @(posedge clk_i);
		xfer(1'b0, tfc_pkg::ADR_RDATA, 32'h0);
		chk("rdata", q, 32'h105);
		chk("rdpar", 32'(st[6]), 32'h1);
		// permit lost mid-write kills it, then go is refused
		xfer(1'b1, tfc_pkg::ADR_CTRL, 32'h9);
		perm <= 1'b0;
		repeat (8) @(posedge clk_i);
		chk("kill", 32'({st[8], st[0]}), 32'h2);
		xfer(1'b1, tfc_pkg::ADR_IRQ_STS, 32'h7f);
		xfer(1'b1, tfc_pkg::ADR_CTRL, 32'h9);
		repeat (6) @(posedge clk_i);
		chk("abort", 32'(st[8]), 32'h1);
		xfer(1'b1, tfc_pkg::ADR_STATREQ, 32'h8);
		xfer(1'b0, tfc_pkg::ADR_STATREQ, 32'h0);
		chk("statreq", q, 32'h18);
		xfer(1'b1, tfc_pkg::ADR_STATREQ, 32'h1);
		xfer(1'b0, tfc_pkg::ADR_STATREQ, 32'h0);
		chk("statreq", q, 32'h01);
		xfer(1'b1, tfc_pkg::ADR_STATREQ, 32'hc);
		xfer(1'b0, tfc_pkg::ADR_STATREQ, 32'h0);
		chk("statreq", q, 32'h0c);
		wrap_up();
	end
endmodule

`default_nettype wire
